// ### test/edh_assertions.sv
`timescale 1ns/1ps

module edh_assertions (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic dma_request_n,
   input wire logic dma_grant_n,
   input wire logic rd_n,
   input wire logic wr_n,
   input wire logic mem_oe,
   input wire logic host_bus_request_n,
   input wire logic host_bus_grant_n,
   input wire logic suspend_bus_tristate_n,
   input wire logic dev_data_oe
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!rst_b_i);

   // ----
   // host ownership
   // ----
   property p_hbg_fall;
      $fell(host_bus_grant_n) |-> !mem_oe && !$past(mem_oe) && !$past(host_bus_request_n, 4);
   endproperty
   a_hbg_fall: assert property (p_hbg_fall)
      else $error("host grant given before interface release");
   property p_hbg_quiet;
      !host_bus_grant_n |-> !mem_oe && rd_n && wr_n && dma_grant_n;
   endproperty
   a_hbg_quiet: assert property (p_hbg_quiet)
      else $error("interface active while host owns bus");
   property p_hbg_rise;
      $rose(host_bus_grant_n) |-> $past(host_bus_request_n, 3);
   endproperty
   a_hbg_rise: assert property (p_hbg_rise)
      else $error("host grant withdrawn without cause");
   property p_mem_back;
      $rose(host_bus_grant_n) && suspend_bus_tristate_n && $past(suspend_bus_tristate_n)
         && $past(suspend_bus_tristate_n, 2) |=> mem_oe;
   endproperty
   a_mem_back: assert property (p_mem_back)
      else $error("interface not regained after host grant");
   property p_suspend;
      $fell(suspend_bus_tristate_n) ##1 !suspend_bus_tristate_n [*2] |=> !mem_oe;
   endproperty
   a_suspend: assert property (p_suspend)
      else $error("interface still driven under suspend");

   // ----
   // dma handshake
   // ----
   property p_start;
      $fell(rd_n) || $fell(wr_n) |-> !$past(dma_request_n, 3);
   endproperty
   a_start: assert property (p_start)
      else $error("strobe without request");
   property p_finish;
      $rose(rd_n) || $rose(wr_n) |-> $past(dma_request_n, 3);
   endproperty
   a_finish: assert property (p_finish)
      else $error("strobe ended while request held low");
   property p_grant_fall;
      $fell(dma_grant_n) |-> !rd_n || !wr_n;
   endproperty
   a_grant_fall: assert property (p_grant_fall)
      else $error("grant low without strobe");
   property p_grant_rise;
      $rose(dma_grant_n) |-> rd_n && wr_n;
   endproperty
   a_grant_rise: assert property (p_grant_rise)
      else $error("grant high while strobe still low");
   property p_data_oe;
      dev_data_oe |-> !wr_n;
   endproperty
   a_data_oe: assert property (p_data_oe)
      else $error("data driven outside write strobe");

   c_host: cover property ($fell(host_bus_grant_n));
   c_write: cover property ($fell(wr_n));
   c_read: cover property ($rose(rd_n));
   c_susp: cover property ($fell(suspend_bus_tristate_n));
endmodule

// ### test/edh_tb.sv
`timescale 1ns/1ps

module edh_tb
   import edh_pkg::*;
   ;
   logic sys_clk_i, rst_b_i, enable_i, dir_write_i, hold_idle_i, boot_mode_i;
   logic go_i, ack_stall_i, host_req_i, suspend_i;
   logic dev_done, dev_busy, released, host_done, host_busy, granted;
   edh_mode_t mode_i;
   logic [3:0] wait_states_i, hold_i;
   logic [31:0] addr_i, seed;
   logic [47:0] wdata_i, rdata_i, dev_rdata, host_wdata;
   int failures, samples_checked, cyc;

   edh_if bus_if ();
   edh_dev i_edh_dev (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus(bus_if.dev),
      .enable_i(enable_i), .mode_i(mode_i), .dir_write_i(dir_write_i),
      .wait_states_i(wait_states_i), .hold_idle_i(hold_idle_i), .boot_mode_i(boot_mode_i),
      .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(dev_rdata), .done_o(dev_done),
      .busy_o(dev_busy), .bus_released_o(released));
   edh_host i_edh_host (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .bus(bus_if.host),
      .go_i(go_i), .hold_i(hold_i), .rdata_i(rdata_i), .ack_stall_i(ack_stall_i),
      .host_req_i(host_req_i), .suspend_i(suspend_i), .wdata_o(host_wdata),
      .done_o(host_done), .busy_o(host_busy), .host_granted_o(granted));
   edh_assertions i_edh_assertions (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
      .dma_request_n(bus_if.dma_request_n), .dma_grant_n(bus_if.dma_grant_n),
      .rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .mem_oe(bus_if.mem_oe),
      .host_bus_request_n(bus_if.host_bus_request_n),
      .host_bus_grant_n(bus_if.host_bus_grant_n),
      .suspend_bus_tristate_n(bus_if.suspend_bus_tristate_n),
      .dev_data_oe(bus_if.dev_data_oe));

   // ----
   // helpers
   // ----
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   function automatic logic [3:0] exp_ms(input logic [31:0] a);
      return ~(4'h1 << a[31:30]);
   endfunction
   function automatic logic exp_page(input edh_mode_t m, input logic [31:0] a);
      return m == EDH_MODE_EXT && a[7:0] == 8'h00;
   endfunction
   task automatic tk();
      @(posedge sys_clk_i);
      #1;
   endtask
   task automatic chk(input string nm, input logic [47:0] e, input logic [47:0] g);
      samples_checked++;
      if (e !== g) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // ----
   // scenarios
   // ----
   task automatic xfer(input int n);
      edh_mode_t m;
      logic [31:0] a, ad_s;
      logic [47:0] d;
      logic [3:0] ws, ms_s, h;
      logic dw, hi, gs, pg_s, dd, hd, sw_s, bm_s;
      int len, rise, gap, cnt;
      m = edh_mode_t'(2'(rnd() % 3));
      a = rnd();
      if (n % 4 == 0) a[7:0] = 8'h00;
      d = {16'h0, rnd()} ^ {rnd(), 16'h0};
      ws = 4'(rnd() % 4);
      {dw, hi} = 2'(rnd());
      h = 4'(rnd() % 4);
      {len, rise, gap, cnt} = '0;
      {gs, pg_s, dd, hd, sw_s, bm_s} = '0;
      ad_s = '0;
      ms_s = '1;
      @(posedge sys_clk_i);
      mode_i <= m;
      dir_write_i <= dw;
      wait_states_i <= ws;
      hold_idle_i <= hi;
      boot_mode_i <= n[0];
      addr_i <= a;
      wdata_i <= d;
      rdata_i <= ~d;
      hold_i <= h;
      ack_stall_i <= n[1];
      go_i <= 1'h1;
      @(posedge sys_clk_i);
      go_i <= 1'h0;
      while (!(dd && hd) && cnt < 300) begin
         tk();
         cnt++;
         if (!bus_if.rd_n || !bus_if.wr_n) begin
            len++;
            if (len == 1) begin
               ad_s = bus_if.addr;
               ms_s = bus_if.memory_select_n;
               pg_s = bus_if.page;
               sw_s = bus_if.sync_write_select_n;
               bm_s = bus_if.boot_memory_select_n;
            end
            if (len == 3) ack_stall_i <= 1'h0;
         end else if (len > 0 && rise == 0) begin
            rise = cnt;
         end
         if (!bus_if.dma_grant_n) gs = 1'h1;
         if (dev_done) gap = cnt - rise;
         dd |= dev_done;
         hd |= host_done;
      end
      ack_stall_i <= 1'h0;
      chk("finished", 1, cnt < 300);
      chk("strobe_len", 1, len >= 1 + ws);
      chk("done_gap", 1 + hi, gap);
      chk("grant_used", m != EDH_MODE_PACED, gs);
      chk("page", exp_page(m, a), pg_s);
      // two-flop sampling each way plus three register edges, then the held cycles
      chk("strobe_prolong", 7 + h, len);
      chk("sync_write", !(dw && m != EDH_MODE_HS), sw_s);
      chk("boot_select", !(n[0] && m == EDH_MODE_HS), bm_s);
      if (m != EDH_MODE_HS) begin
         chk("addr", a, ad_s);
         chk("selects", exp_ms(a), ms_s);
      end
      if (dw) chk("write_data", d, host_wdata);
      else chk("read_data", ~d, dev_rdata);
      cnt = 0;
      while ((dev_busy || host_busy) && cnt < 50) begin
         tk();
         cnt++;
      end
      chk("idle", 0, dev_busy || host_busy);
      $display("test xfer %0d mode %0d done", n, m);
   endtask

   task automatic host_own();
      int cnt;
      cnt = 0;
      @(posedge sys_clk_i);
      host_req_i <= 1'h1;
      while (!granted && cnt < 30) begin
         tk();
         cnt++;
      end
      chk("released", 1, released);
      chk("strobes_idle", 2'h3, {bus_if.rd_n, bus_if.wr_n});
      @(posedge sys_clk_i);
      host_req_i <= 1'h0;
      cnt = 0;
      while (released && cnt < 30) begin
         tk();
         cnt++;
      end
      chk("hbg_high", 1, bus_if.host_bus_grant_n);
      chk("regained", 1, cnt < 30);
      @(posedge sys_clk_i);
      suspend_i <= 1'h1;
      repeat (5) tk();
      chk("suspended", 1, released);
      @(posedge sys_clk_i);
      suspend_i <= 1'h0;
      repeat (5) tk();
      chk("resumed", 0, released);
      $display("test host and suspend done");
   endtask

   initial begin
      sys_clk_i = 1'h0;
      forever #50 sys_clk_i = ~sys_clk_i;
   end

   always @(posedge sys_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         end_of_test();
      end
   end

   initial begin
      {rst_b_i, dir_write_i, hold_idle_i, boot_mode_i} = '0;
      {go_i, ack_stall_i, host_req_i, suspend_i} = '0;
      enable_i = 1'h1;
      mode_i = EDH_MODE_HS;
      {wait_states_i, hold_i, addr_i, wdata_i, rdata_i} = '0;
      {failures, samples_checked, cyc} = '0;
      seed = 32'hd71f;
      repeat (3) @(posedge sys_clk_i);
      rst_b_i <= 1'h1;
      for (int n = 0; n < 24; n++) begin
         xfer(n);
         if (n % 8 == 7) host_own();
      end
      end_of_test();
   end
endmodule

// ### verilog/edh_consts.svh
`ifndef EDH_CONSTS_SVH
`define EDH_CONSTS_SVH

// ----------------------------------------------------------------
// bus widths and reset values
// ----------------------------------------------------------------
`define EDH_ADDR_W 32
`define EDH_DATA_W 48
`define EDH_MS_W 4
`define EDH_WAIT_W 4
`define EDH_ADDR_RST 32'h0000_0000
`define EDH_DATA_RST 48'h0000_0000_0000

// ----------------------------------------------------------------
// field positions of the address
// ----------------------------------------------------------------
`define EDH_MS_LSB 30
`define EDH_PAGE_BITS 8

// ----------------------------------------------------------------
// timing counts in clock cycles
// ----------------------------------------------------------------
`define EDH_SYNC_STAGES 2
`define EDH_HI_CYCLES 1

`endif

// ### verilog/edh_dev.sv
// Overview of operation
// - peripheral starts each transfer with request low
// - handshake mode: grant strobes external data
// - external handshake drives address, strobes, selects, grant
// - paced master uses strobes and acknowledge, no grant
// - request low holds off write completion
// - request low prolongs read by whole cycles
// - request recognised at its sampled clock edge
// - wait states lengthen strobe; hold adds gap
// - release interface before host grant, regain after
// - release and resume synchronous at transitions, suspend
// - data enable follows the same release timing
`timescale 1ns/1ps
`include "edh_consts.svh"

module edh_dev
   import edh_pkg::*;
#(
   parameter int ADDR_W = `EDH_ADDR_W,
   parameter int DATA_W = `EDH_DATA_W,
   parameter int WAIT_W = `EDH_WAIT_W,
   parameter int PAGE_BITS = `EDH_PAGE_BITS
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   edh_if.dev bus,
   input wire logic enable_i,
   input wire edh_mode_t mode_i,
   input wire logic dir_write_i,
   input wire logic [WAIT_W-1:0] wait_states_i,
   input wire logic hold_idle_i,
   input wire logic boot_mode_i,
   input wire logic [ADDR_W-1:0] addr_i,
   input wire logic [DATA_W-1:0] wdata_i,
   output logic [DATA_W-1:0] rdata_o,
   output logic done_o,
   output logic busy_o,
   output logic bus_released_o
);
   typedef enum logic [2:0] {
      D_IDLE,
      D_STROBE,
      D_EXTEND,
      D_GAP,
      D_RELEASE
   } edh_dst_t;

   typedef enum logic [1:0] {
      B_OWN,
      B_DROP,
      B_GRANT,
      B_REGAIN
   } edh_bst_t;

   edh_dst_t st_q, st_d;
   edh_bst_t bst_q, bst_d;
   logic [WAIT_W-1:0] cnt_q, cnt_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic dir_q, dir_d;
   edh_mode_t mode_q, mode_d;
   logic grant_n_q, grant_n_d;
   logic rd_n_q, rd_n_d;
   logic wr_n_q, wr_n_d;
   logic done_q, done_d;
   logic mem_oe_q, mem_oe_d;
   logic hbg_n_q, hbg_n_d;
   logic req_s, ack_s, hbr_s, suspend_bus_tristate_n_s;
   logic [DATA_W-1:0] data_s;
   logic active, stall, own;

   initial begin
      if (ADDR_W != `EDH_ADDR_W || DATA_W != `EDH_DATA_W || WAIT_W < 1 ||
          PAGE_BITS < 1 || PAGE_BITS >= ADDR_W) begin
         $error("edh_dev: bad parameters");
      end
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   edh_sync #(.W(4), .RST(4'hf)) u_ctl (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .d_i({bus.dma_request_n, bus.ack, bus.host_bus_request_n,
            bus.suspend_bus_tristate_n}),
      .q_o({req_s, ack_s, hbr_s, suspend_bus_tristate_n_s})
   );

   edh_sync #(.W(DATA_W), .RST('0)) u_data (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .d_i(bus.data),
      .q_o(data_s)
   );

   // no transfer starts while the interface is not ours or suspended
   assign own = (bst_q == B_OWN) && mem_oe_q;
   assign stall = !own;
   assign active = (st_q == D_STROBE) || (st_q == D_EXTEND);

   // ----------------------------------------------------------------
   // transfer sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      addr_d = addr_q;
      rdata_d = rdata_q;
      dir_d = dir_q;
      mode_d = mode_q;
      grant_n_d = grant_n_q;
      rd_n_d = rd_n_q;
      wr_n_d = wr_n_q;
      done_d = 1'b0;
      case (st_q)
         D_IDLE: begin
            if (enable_i && !req_s && !stall) begin
               addr_d = addr_i;
               dir_d = dir_write_i;
               mode_d = mode_i;
               cnt_d = wait_states_i;
               grant_n_d = (mode_i == EDH_MODE_PACED);
               rd_n_d = dir_write_i;
               wr_n_d = !dir_write_i;
               st_d = D_STROBE;
            end
         end
         D_STROBE: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               st_d = D_EXTEND;
            end
         end
         D_EXTEND: begin
            // request low holds the access, ack low stalls an external handshake or paced access
            if (req_s && (ack_s || mode_q == EDH_MODE_HS)) begin
               if (!dir_q) begin
                  rdata_d = data_s;
               end
               grant_n_d = 1'b1;
               rd_n_d = 1'b1;
               wr_n_d = 1'b1;
               cnt_d = hold_idle_i ? WAIT_W'(`EDH_HI_CYCLES) : '0;
               st_d = D_GAP;
            end
         end
         D_GAP: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               done_d = 1'b1;
               st_d = D_RELEASE;
            end
         end
         D_RELEASE: begin
            // one transfer per request: wait for it to rise first
            if (req_s) begin
               st_d = D_IDLE;
            end
         end
         default: st_d = D_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= D_IDLE;
         cnt_q <= '0;
         addr_q <= `EDH_ADDR_RST;
         rdata_q <= `EDH_DATA_RST;
         dir_q <= 1'b0;
         mode_q <= EDH_MODE_HS;
         grant_n_q <= 1'b1;
         rd_n_q <= 1'b1;
         wr_n_q <= 1'b1;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         addr_q <= addr_d;
         rdata_q <= rdata_d;
         dir_q <= dir_d;
         mode_q <= mode_d;
         grant_n_q <= grant_n_d;
         rd_n_q <= rd_n_d;
         wr_n_q <= wr_n_d;
         done_q <= done_d;
      end
   end

   // ----------------------------------------------------------------
   // bus ownership
   // ----------------------------------------------------------------
   always_comb begin
      bst_d = bst_q;
      hbg_n_d = hbg_n_q;
      mem_oe_d = mem_oe_q;
      case (bst_q)
         B_OWN: begin
            if (!hbr_s && (st_q == D_IDLE)) begin
               mem_oe_d = 1'b0;
               bst_d = B_DROP;
            end else begin
               mem_oe_d = suspend_bus_tristate_n_s;
            end
         end
         B_DROP: begin
            hbg_n_d = 1'b0;
            bst_d = B_GRANT;
         end
         B_GRANT: begin
            if (hbr_s) begin
               hbg_n_d = 1'b1;
               bst_d = B_REGAIN;
            end
         end
         B_REGAIN: begin
            mem_oe_d = suspend_bus_tristate_n_s;
            bst_d = B_OWN;
         end
         default: bst_d = B_OWN;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bst_q <= B_OWN;
         hbg_n_q <= 1'b1;
         mem_oe_q <= 1'b1;
      end else begin
         bst_q <= bst_d;
         hbg_n_q <= hbg_n_d;
         mem_oe_q <= mem_oe_d;
      end
   end

   // ----------------------------------------------------------------
   // pin drivers
   // ----------------------------------------------------------------
   assign bus.mem_oe = mem_oe_q;
   assign bus.dma_grant_n = grant_n_q;
   assign bus.rd_n = rd_n_q;
   assign bus.wr_n = wr_n_q;
   assign bus.addr = (mode_q != EDH_MODE_HS) ? addr_q : '0;
   assign bus.sync_write_select_n = !(active && dir_q && mode_q != EDH_MODE_HS);
   assign bus.page = active && (mode_q == EDH_MODE_EXT) && (addr_q[PAGE_BITS-1:0] == '0);
   assign bus.memory_select_n = (active && mode_q != EDH_MODE_HS) ?
      ~(`EDH_MS_W'(1) << addr_q[`EDH_MS_LSB +: 2]) : '1;
   assign bus.boot_memory_select_n = !(boot_mode_i && active && mode_q == EDH_MODE_HS);
   assign bus.host_bus_grant_n = hbg_n_q;
   assign bus.dev_data = wdata_i;
   assign bus.dev_data_oe = mem_oe_q && active && dir_q;
   assign rdata_o = rdata_q;
   assign done_o = done_q;
   assign busy_o = (st_q != D_IDLE);
   assign bus_released_o = !mem_oe_q;
endmodule

// ### verilog/edh_host.sv
`timescale 1ns/1ps
`include "edh_consts.svh"

module edh_host
   import edh_pkg::*;
#(
   parameter int DATA_W = `EDH_DATA_W,
   parameter int WAIT_W = `EDH_WAIT_W
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   edh_if.host bus,
   input wire logic go_i,
   input wire logic [WAIT_W-1:0] hold_i,
   input wire logic [DATA_W-1:0] rdata_i,
   input wire logic ack_stall_i,
   input wire logic host_req_i,
   input wire logic suspend_i,
   output logic [DATA_W-1:0] wdata_o,
   output logic done_o,
   output logic busy_o,
   output logic host_granted_o
);
   typedef enum logic [1:0] {
      H_IDLE,
      H_REQ,
      H_HOLD,
      H_END
   } edh_hst_t;

   edh_hst_t st_q, st_d;
   logic [WAIT_W-1:0] cnt_q, cnt_d;
   logic [DATA_W-1:0] wdata_q, wdata_d;
   logic req_n_q, req_n_d;
   logic doe_q, doe_d;
   logic done_q, done_d;
   logic rd_s, wr_s, hbg_s;
   logic [DATA_W-1:0] data_s;

   initial begin
      if (DATA_W != `EDH_DATA_W || WAIT_W < 1) $error("edh_host: bad parameters");
   end

   // ----------------------------------------------------------------
   // pin synchronisers
   // ----------------------------------------------------------------
   edh_sync #(.W(3), .RST(3'h7)) u_strb (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .d_i({bus.rd_n, bus.wr_n, bus.host_bus_grant_n}),
      .q_o({rd_s, wr_s, hbg_s})
   );

   edh_sync #(.W(DATA_W), .RST('0)) u_data (
      .sys_clk_i(sys_clk_i),
      .rst_b_i(rst_b_i),
      .d_i(bus.data),
      .q_o(data_s)
   );

   // ----------------------------------------------------------------
   // peripheral sequencer
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      cnt_d = cnt_q;
      wdata_d = wdata_q;
      req_n_d = req_n_q;
      doe_d = doe_q;
      done_d = 1'b0;
      case (st_q)
         H_IDLE: begin
            if (go_i) begin
               req_n_d = 1'b0;
               st_d = H_REQ;
            end
         end
         H_REQ: begin
            if (!rd_s || !wr_s) begin
               cnt_d = hold_i;
               doe_d = !rd_s;
               st_d = H_HOLD;
            end
         end
         H_HOLD: begin
            if (cnt_q != '0) begin
               cnt_d = cnt_q - 1'b1;
            end else begin
               req_n_d = 1'b1;
               if (!wr_s) begin
                  wdata_d = data_s;
               end
               st_d = H_END;
            end
         end
         H_END: begin
            if (rd_s && wr_s) begin
               doe_d = 1'b0;
               done_d = 1'b1;
               st_d = H_IDLE;
            end
         end
         default: st_d = H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         st_q <= H_IDLE;
         cnt_q <= '0;
         wdata_q <= '0;
         req_n_q <= 1'b1;
         doe_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         st_q <= st_d;
         cnt_q <= cnt_d;
         wdata_q <= wdata_d;
         req_n_q <= req_n_d;
         doe_q <= doe_d;
         done_q <= done_d;
      end
   end

   assign bus.dma_request_n = req_n_q;
   assign bus.host_data = rdata_i;
   assign bus.host_data_oe = doe_q;
   assign bus.ack = !ack_stall_i;
   assign bus.host_bus_request_n = !host_req_i;
   assign bus.suspend_bus_tristate_n = !suspend_i;
   assign wdata_o = wdata_q;
   assign done_o = done_q;
   assign busy_o = (st_q != H_IDLE);
   assign host_granted_o = !hbg_s;
endmodule

// ### verilog/edh_if.sv
`timescale 1ns/1ps
`include "edh_consts.svh"

interface edh_if;
   logic dma_request_n;
   logic dma_grant_n;
   logic rd_n;
   logic wr_n;
   logic sync_write_select_n;
   logic page;
   logic [`EDH_MS_W-1:0] memory_select_n;
   logic boot_memory_select_n;
   logic [`EDH_ADDR_W-1:0] addr;
   logic mem_oe;
   logic ack;
   logic host_bus_request_n;
   logic host_bus_grant_n;
   logic suspend_bus_tristate_n;
   logic [`EDH_DATA_W-1:0] dev_data;
   logic dev_data_oe;
   logic [`EDH_DATA_W-1:0] host_data;
   logic host_data_oe;
   logic [`EDH_DATA_W-1:0] data;

   // shared data bus: whoever enables drives, an idle bus reads zero
   assign data = dev_data_oe ? dev_data : (host_data_oe ? host_data : '0);

   modport dev (
      input dma_request_n, ack, host_bus_request_n, suspend_bus_tristate_n, data,
      output dma_grant_n, rd_n, wr_n, sync_write_select_n, page, memory_select_n,
      output boot_memory_select_n, addr, mem_oe, host_bus_grant_n, dev_data, dev_data_oe
   );

   modport host (
      input dma_grant_n, rd_n, wr_n, mem_oe, host_bus_grant_n, data,
      output dma_request_n, ack, host_bus_request_n, suspend_bus_tristate_n,
      output host_data, host_data_oe
   );
endinterface

// ### verilog/edh_pkg.sv
package edh_pkg;

   // transfer mode of the dma channel
   typedef enum logic [1:0] {
      EDH_MODE_HS,
      EDH_MODE_EXT,
      EDH_MODE_PACED
   } edh_mode_t;

endpackage

// ### verilog/edh_sync.sv
`timescale 1ns/1ps
`include "edh_consts.svh"

module edh_sync #(
   parameter int W = 1,
   parameter logic [W-1:0] RST = '1
) (
   input wire logic sys_clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_q;
   logic [W-1:0] sync_q;

   initial begin
      if (W < 1) $error("edh_sync: width must be at least 1");
   end

   always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         meta_q <= RST;
         sync_q <= RST;
      end else begin
         meta_q <= d_i;
         sync_q <= meta_q;
      end
   end

   assign q_o = sync_q;
endmodule
